// *** rtl/pm_snap_defs.vh ***
// Constants for the power monitor snapshot controller
`ifndef PM_SNAP_DEFS_VH
`define PM_SNAP_DEFS_VH
`define CLK_HZ          125000000
`define MS_PER_S        1000
`define SNAP_HOLD_MS    1
`define RATE_1024       1024
`define RATE_256        256
`define RATE_64         64
`define RATE_8          8
`define RATE_CODE_1024  2'h0
`define RATE_CODE_256   2'h1
`define RATE_CODE_64    2'h2
`define RATE_CODE_8     2'h3
`define CMD_SNAP_CLR    8'h00
`define CMD_SNAP_GRP    8'h1E
`define CMD_SNAP_KEEP   8'h1F
`define REG_CTRL        8'h01
`define REG_STATUS      8'h02
`define REG_COUNT_HI    8'h03
`define REG_COUNT_MID   8'h04
`define REG_COUNT_LO    8'h05
`define CTRL_RESET      8'h0F
`define CTRL_RATE_HI    7
`define CTRL_RATE_LO    6
`define CTRL_SLEEP      5
`define CTRL_EN_HI      3
`define CTRL_EN_LO      0
`define EN_ALL          4'hF
`define GEN_CALL_ADDR   7'h00
`define SEL_VBUS_HI     4'h0
`define SEL_VBUS_LO     4'h1
`define SEL_VSNS_HI     4'h2
`define SEL_VSNS_LO     4'h3
`define SEL_PWR_B3      4'h4
`define SEL_PWR_B2      4'h5
`define SEL_PWR_B1      4'h6
`define SEL_PWR_B0      4'h7
`define SEL_ACC_B5      4'h8
`define SEL_ACC_B4      4'h9
`define SEL_ACC_B3      4'hA
`define SEL_ACC_B2      4'hB
`define SEL_ACC_B1      4'hC
`define SEL_ACC_B0      4'hD
`endif

// *** rtl/chan_accum.v ***
// One channel: power product, accumulator, completed and snapshot values
`timescale 1ns/1ps
`include "pm_snap_defs.vh"
module chan_accum #(
    parameter VW = 16,
    parameter AW = 48
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          sample_we_i,
    input  wire [VW-1:0] vbus_i,
    input  wire [VW-1:0] vsense_i,
    input  wire          round_end_i,
    input  wire          snap_i,
    input  wire          snap_clr_i,
    input  wire [3:0]    sel_i,
    output reg  [7:0]    rd_byte_o
);
    wire [29:0]   prod = vbus_i[VW-1:2] * vsense_i;
    reg  [VW-1:0] vbus_l;
    reg  [VW-1:0] vsns_l;
    reg  [29:0]   pwr_l;
    reg  [VW-1:0] vbus_c;
    reg  [VW-1:0] vsns_c;
    reg  [29:0]   pwr_c;
    reg  [VW-1:0] vbus_s;
    reg  [VW-1:0] vsns_s;
    reg  [31:0]   pwr_s;
    reg  [AW-1:0] acc;
    reg  [AW-1:0] acc_s;
    reg  [7:0]    next_byte;

    always @(posedge clk_i) begin
        if (rst_i) begin
            vbus_l <= {VW{1'b0}};
            vsns_l <= {VW{1'b0}};
            pwr_l  <= 30'h0;
            vbus_c <= {VW{1'b0}};
            vsns_c <= {VW{1'b0}};
            pwr_c  <= 30'h0;
            vbus_s <= {VW{1'b0}};
            vsns_s <= {VW{1'b0}};
            pwr_s  <= 32'h0;
            acc    <= {AW{1'b0}};
            acc_s  <= {AW{1'b0}};
        end else begin
            if (sample_we_i) begin
                vbus_l <= vbus_i;
                vsns_l <= vsense_i;
                pwr_l  <= prod;
            end
            if (round_end_i) begin
                vbus_c <= vbus_l;
                vsns_c <= vsns_l;
                pwr_c  <= pwr_l;
            end
            if (snap_i) begin
                vbus_s <= vbus_c;
                vsns_s <= vsns_c;
                pwr_s  <= {2'h0, pwr_c};
                acc_s  <= acc;
            end
            if (snap_i && snap_clr_i)
                acc <= {AW{1'b0}};
            else if (sample_we_i)
                acc <= acc + {{(AW-30){1'b0}}, prod};
            rd_byte_o <= next_byte;
        end
    end

    always @* begin
        case (sel_i)
            `SEL_VBUS_HI: next_byte = vbus_s[15:8];
            `SEL_VBUS_LO: next_byte = vbus_s[7:0];
            `SEL_VSNS_HI: next_byte = vsns_s[15:8];
            `SEL_VSNS_LO: next_byte = vsns_s[7:0];
            `SEL_PWR_B3:  next_byte = pwr_s[31:24];
            `SEL_PWR_B2:  next_byte = pwr_s[23:16];
            `SEL_PWR_B1:  next_byte = pwr_s[15:8];
            `SEL_PWR_B0:  next_byte = pwr_s[7:0];
            `SEL_ACC_B5:  next_byte = acc_s[47:40];
            `SEL_ACC_B4:  next_byte = acc_s[39:32];
            `SEL_ACC_B3:  next_byte = acc_s[31:24];
            `SEL_ACC_B2:  next_byte = acc_s[23:16];
            `SEL_ACC_B1:  next_byte = acc_s[15:8];
            `SEL_ACC_B0:  next_byte = acc_s[7:0];
            default:      next_byte = 8'h00;
        endcase
    end
endmodule // chan_accum

// *** rtl/power_monitor_snapshot_control.v ***
// Sequencer, serial slave and snapshot control of the power monitor
`timescale 1ns/1ps
`include "pm_snap_defs.vh"
//Contract
// - After reset, run active, sampling enabled channels at 1024 per second.
// - Master may program rates of 256, 64 or 8 per second.
// - Slow pin high forces 8 per second; low keeps programmed rate.
// - Sleep between rounds when rate below 1024 or fewer than four channels.
// - Sample both voltages together, multiply to power, accumulate each conversion; one sampled in the same cycle as a resetting snapshot is not accumulated.
// - Convert enabled channels one after another within each round.
// - Resetting snapshot loads readable results; they hold until next snapshot.
// - Results stable within 1 ms, readable until next snapshot.
// - Resetting snapshot clears accumulators and count; sampling continues.
// - Snapshot copies values of the last completed round.
// - Control changes follow snapshot; commands within 1 ms are NACKed.
// - New control value applies at round end after a snapshot.
// - Group command 1Eh acts like resetting snapshot, also at general call.
// - Group command at a specific address acts only on that device.
// - Keeping snapshot 1Fh updates results, applies control, keeps accumulators.
// - Sleep keeps all digital state.
// - Sleep bit plus snapshot enters sleep; cleared bit plus snapshot resumes.
// - No sleep for other reasons; bus logic runs in sleep too.
// - Power-down low holds everything inactive and discards all state.
// - Power-down release restarts with default settings.
module power_monitor_snapshot_control #(
    parameter [6:0] SLAVE_ADDR  = 7'h10,
    parameter       HOLD_CYCLES = `CLK_HZ / `MS_PER_S * `SNAP_HOLD_MS,
    parameter       PER_1024    = `CLK_HZ / `RATE_1024,
    parameter       PER_256     = `CLK_HZ / `RATE_256,
    parameter       PER_64      = `CLK_HZ / `RATE_64,
    parameter       PER_8       = `CLK_HZ / `RATE_8
) (
    input  wire        ref_clk_i,
    input  wire        rst_i,
    input  wire        power_down_n_i,
    input  wire        scl_i,
    input  wire        sda_i,
    output reg         sda_o,
    output reg         sda_oe_o,
    input  wire        slow_i,
    output reg  [1:0]  mux_sel_o,
    output reg         conv_start_o,
    input  wire        conv_done_i,
    input  wire [15:0] vbus_i,
    input  wire [15:0] vsense_i,
    output reg         sleep_o
);
    localparam I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h2, I_WR = 3'h3;
    localparam I_WACK = 3'h4, I_RD = 3'h5, I_RACK = 3'h6;
    localparam S_WAIT = 2'h0, S_START = 2'h1, S_BUSY = 2'h2, S_END = 2'h3;

    reg         scl_s1, scl_s2, scl_q;
    reg         sda_s1, sda_s2, sda_q;
    reg         slow_s1, slow_s2;
    reg         pdn_s1, pdn_s2;
    wire        irst = rst_i | ~pdn_s2;
    wire        scl_rise = scl_s2 & ~scl_q;
    wire        scl_fall = ~scl_s2 & scl_q;
    wire        bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
    wire        bus_stop = scl_s2 & scl_q & ~sda_q & sda_s2;

    reg  [2:0]  istate;
    reg  [3:0]  bitcnt;
    reg  [7:0]  shreg;
    reg         rw, gc, first;
    reg  [7:0]  ptr;
    reg  [7:0]  ctrl_pend;
    reg  [7:0]  ctrl_act;
    reg         pend;
    reg         snap, snap_clr;
    reg  [23:0] hold_cnt;
    wire        busy = (hold_cnt != 24'h0);
    reg  [1:0]  sstate;
    reg  [23:0] per_cnt;
    reg  [23:0] count;
    reg  [23:0] count_s;
    reg         sample_we, round_end;
    reg  [7:0]  rd_mux;
    reg  [23:0] next_period;
    wire [31:0] ch_bytes;
    wire [3:0]  en = ctrl_act[`CTRL_EN_HI:`CTRL_EN_LO];
    wire [1:0]  rate = ctrl_act[`CTRL_RATE_HI:`CTRL_RATE_LO];
    wire        man_sleep = ctrl_act[`CTRL_SLEEP];
    wire        auto_sleep = slow_s2 | (rate != `RATE_CODE_1024) | (en != `EN_ALL);
    wire [7:0]  wbyte = {shreg[6:0], sda_s2};
    wire        is_snap = (wbyte == `CMD_SNAP_CLR) | (wbyte == `CMD_SNAP_GRP) |
                          (wbyte == `CMD_SNAP_KEEP);
    wire        last_ch = (mux_sel_o == 2'h3);

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_ch
            chan_accum #(
                .VW (16),
                .AW (48)
            ) u_ch (
                .clk_i       (ref_clk_i),
                .rst_i       (irst),
                .sample_we_i (sample_we & (mux_sel_o == g)),
                .vbus_i      (vbus_i),
                .vsense_i    (vsense_i),
                .round_end_i (round_end),
                .snap_i      (snap),
                .snap_clr_i  (snap_clr),
                .sel_i       (ptr[3:0]),
                .rd_byte_o   (ch_bytes[8*g+7:8*g])
            );
        end
    endgenerate

    // Pin synchronisers
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            pdn_s1 <= 1'b0;
            pdn_s2 <= 1'b0;
        end else begin
            pdn_s1 <= power_down_n_i;
            pdn_s2 <= pdn_s1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (irst) begin
            scl_s1  <= 1'b1;
            scl_s2  <= 1'b1;
            scl_q   <= 1'b1;
            sda_s1  <= 1'b1;
            sda_s2  <= 1'b1;
            sda_q   <= 1'b1;
            slow_s1 <= 1'b0;
            slow_s2 <= 1'b0;
        end else begin
            scl_s1  <= scl_i;
            scl_s2  <= scl_s1;
            scl_q   <= scl_s2;
            sda_s1  <= sda_i;
            sda_s2  <= sda_s1;
            sda_q   <= sda_s2;
            slow_s1 <= slow_i;
            slow_s2 <= slow_s1;
        end
    end

    // Read data selection
    always @* begin
        if (ptr == `REG_CTRL)
            rd_mux = ctrl_pend;
        else if (ptr == `REG_STATUS)
            rd_mux = {rate, man_sleep, slow_s2, pend, busy, sleep_o, 1'b0};
        else if (ptr == `REG_COUNT_HI)
            rd_mux = count_s[23:16];
        else if (ptr == `REG_COUNT_MID)
            rd_mux = count_s[15:8];
        else if (ptr == `REG_COUNT_LO)
            rd_mux = count_s[7:0];
        else if (ptr[7:4] >= 4'h1 && ptr[7:4] <= 4'h4)
            rd_mux = ch_bytes[8*(ptr[5:4]-2'h1) +: 8];
        else
            rd_mux = 8'h00;
    end

    // Serial slave; runs in sleep as well as active
    always @(posedge ref_clk_i) begin
        if (irst) begin
            istate    <= I_IDLE;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            rw        <= 1'b0;
            gc        <= 1'b0;
            first     <= 1'b0;
            ptr       <= 8'h00;
            ctrl_pend <= `CTRL_RESET;
            snap      <= 1'b0;
            snap_clr  <= 1'b0;
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
            hold_cnt  <= 24'h0;
        end else begin
            sda_o    <= 1'b0;
            snap     <= 1'b0;
            snap_clr <= 1'b0;
            if (snap)
                hold_cnt <= HOLD_CYCLES[23:0];
            else if (busy)
                hold_cnt <= hold_cnt - 24'h1;
            if (bus_start) begin
                istate   <= I_ADDR;
                bitcnt   <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (bus_stop) begin
                istate   <= I_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (istate)
                    I_ADDR: begin
                        if (scl_rise) begin
                            shreg  <= wbyte;
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            rw <= shreg[0];
                            gc <= (shreg[7:1] == `GEN_CALL_ADDR);
                            if (((shreg[7:1] == SLAVE_ADDR) ||
                                 (shreg[7:1] == `GEN_CALL_ADDR && !shreg[0])) &&
                                !busy) begin
                                sda_oe_o <= 1'b1;
                                istate   <= I_AACK;
                                shreg    <= rd_mux;
                            end else begin
                                istate <= I_IDLE;
                            end
                        end
                    end
                    I_AACK: begin
                        if (scl_fall) begin
                            bitcnt <= 4'h0;
                            first  <= 1'b1;
                            if (rw) begin
                                sda_oe_o <= ~shreg[7];
                                istate   <= I_RD;
                            end else begin
                                sda_oe_o <= 1'b0;
                                istate   <= I_WR;
                            end
                        end
                    end
                    I_WR: begin
                        if (scl_rise) begin
                            shreg  <= wbyte;
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            istate <= I_WACK;
                            sda_oe_o <= ~gc | (first && shreg == `CMD_SNAP_GRP);
                            if (first && !gc && (shreg == `CMD_SNAP_CLR ||
                                shreg == `CMD_SNAP_GRP || shreg == `CMD_SNAP_KEEP)) begin
                                snap     <= 1'b1;
                                snap_clr <= (shreg != `CMD_SNAP_KEEP);
                            end else if (first && gc && shreg == `CMD_SNAP_GRP) begin
                                snap     <= 1'b1;
                                snap_clr <= 1'b1;
                            end else if (first && !gc) begin
                                ptr <= shreg;
                            end else if (!gc) begin
                                if (ptr == `REG_CTRL)
                                    ctrl_pend <= shreg;
                                ptr <= ptr + 8'h1;
                            end
                        end
                    end
                    I_WACK: begin
                        if (scl_fall) begin
                            sda_oe_o <= 1'b0;
                            bitcnt   <= 4'h0;
                            first    <= 1'b0;
                            istate   <= (gc || !is_snap) ? I_WR : I_WR;
                        end
                    end
                    I_RD: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h7) begin
                                sda_oe_o <= 1'b0;
                                istate   <= I_RACK;
                            end else begin
                                sda_oe_o <= ~shreg[6];
                                shreg    <= {shreg[6:0], 1'b0};
                                bitcnt   <= bitcnt + 4'h1;
                            end
                        end
                    end
                    I_RACK: begin
                        if (scl_rise) begin
                            if (sda_s2)
                                istate <= I_IDLE;
                            else
                                ptr <= ptr + 8'h1;
                        end else if (scl_fall) begin
                            shreg    <= rd_mux;
                            sda_oe_o <= ~rd_mux[7];
                            bitcnt   <= 4'h0;
                            istate   <= I_RD;
                        end
                    end
                    default: istate <= I_IDLE;
                endcase
            end
        end
    end

    // Period for the next round
    always @* begin
        if (slow_s2)
            next_period = PER_8[23:0];
        else begin
            case (rate)
                `RATE_CODE_256: next_period = PER_256[23:0];
                `RATE_CODE_64:  next_period = PER_64[23:0];
                `RATE_CODE_8:   next_period = PER_8[23:0];
                default:        next_period = PER_1024[23:0];
            endcase
        end
    end

    // Round-robin sequencer; sleep only holds off rounds, state is kept
    always @(posedge ref_clk_i) begin
        if (irst) begin
            sstate       <= S_WAIT;
            per_cnt      <= 24'h0;
            mux_sel_o    <= 2'h0;
            conv_start_o <= 1'b0;
            sample_we    <= 1'b0;
            round_end    <= 1'b0;
            sleep_o      <= 1'b0;
            ctrl_act     <= `CTRL_RESET;
            pend         <= 1'b0;
            count        <= 24'h0;
            count_s      <= 24'h0;
        end else begin
            conv_start_o <= 1'b0;
            sample_we    <= 1'b0;
            round_end    <= 1'b0;
            if (per_cnt != 24'h0)
                per_cnt <= per_cnt - 24'h1;
            if (snap)
                count_s <= count;
            if (snap && snap_clr)
                count <= 24'h0;
            else if (round_end)
                count <= count + 24'h1;
            if (snap)
                pend <= 1'b1;
            case (sstate)
                S_WAIT: begin
                    sleep_o <= man_sleep | (en == 4'h0) | auto_sleep;
                    if (pend && !snap && (man_sleep || en == 4'h0)) begin
                        ctrl_act <= ctrl_pend;
                        pend     <= 1'b0;
                    end else if (per_cnt == 24'h0 && !man_sleep && en != 4'h0) begin
                        sleep_o   <= 1'b0;
                        per_cnt   <= next_period - 24'h1;
                        mux_sel_o <= 2'h0;
                        sstate    <= S_START;
                    end
                end
                S_START: begin
                    if (en[mux_sel_o]) begin
                        conv_start_o <= 1'b1;
                        sstate       <= S_BUSY;
                    end else if (last_ch) begin
                        sstate <= S_END;
                    end else begin
                        mux_sel_o <= mux_sel_o + 2'h1;
                    end
                end
                S_BUSY: begin
                    if (conv_done_i) begin
                        sample_we <= 1'b1;
                        sstate    <= S_END;
                    end
                end
                S_END: begin
                    if (sample_we && !last_ch) begin
                        mux_sel_o <= mux_sel_o + 2'h1;
                        sstate    <= S_START;
                    end else if (!sample_we && !last_ch) begin
                        mux_sel_o <= mux_sel_o + 2'h1;
                        sstate    <= S_START;
                    end else begin
                        round_end <= 1'b1;
                        if (pend && !snap) begin
                            ctrl_act <= ctrl_pend;
                            pend     <= 1'b0;
                        end
                        sstate <= S_WAIT;
                    end
                end
                default: sstate <= S_WAIT;
            endcase
        end
    end
endmodule // power_monitor_snapshot_control

// *** rtl/unused_placeholder_never.v ***
// Intentionally empty file removed

// *** testbench/pm_snap_checker_sva.sv ***
// Port assertions for the snapshot controller
`timescale 1ns/1ps
module pm_snap_checker (
    input wire       ref_clk_i,
    input wire       rst_i,
    input wire       power_down_n_i,
    input wire       scl_i,
    input wire       sda_oe_o,
    input wire [1:0] mux_sel_o,
    input wire       conv_start_o,
    input wire       conv_done_i,
    input wire       sleep_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
        else $error("start longer than a cycle");
    a_start_waits: assert property (conv_start_o |=> !conv_start_o until conv_done_i)
        else $error("start before done");
    a_release_idle: assert property ($fell(rst_i) |-> !sda_oe_o && !sleep_o && mux_sel_o == 2'h0)
        else $error("outputs busy at release");
    a_first_round: assert property ($fell(rst_i) |-> ##[1:12] conv_start_o)
        else $error("no round after reset");
    a_pd_quiet: assert property (!power_down_n_i [*5] |-> !sda_oe_o && !conv_start_o && !sleep_o)
        else $error("active in power down");
    a_pd_restart: assert property ($rose(power_down_n_i) |-> ##[1:16] conv_start_o)
        else $error("no restart after power down");
    a_asleep_idle: assert property (sleep_o |-> !conv_start_o)
        else $error("conversion while asleep");
    a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved with clock high");
endmodule // pm_snap_checker
bind power_monitor_snapshot_control pm_snap_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .power_down_n_i(power_down_n_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .mux_sel_o(mux_sel_o),
    .conv_start_o(conv_start_o), .conv_done_i(conv_done_i), .sleep_o(sleep_o));

// *** testbench/i2c_host_model.sv ***
// Serial bus master model, 160 ns bit period
`timescale 1ns/1ps
module i2c_host_model (
    input  wire ref_clk_i,
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_low_o
);
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task q;
        repeat (5) @(posedge ref_clk_i);
    endtask
    task bus_start;
        sda_low_o <= 1'b0; scl_o <= 1'b1; q; q;
        sda_low_o <= 1'b1; q; q;
        scl_o <= 1'b0; q;
    endtask
    task bus_stop;
        sda_low_o <= 1'b1; q;
        scl_o <= 1'b1; q; q;
        sda_low_o <= 1'b0; q; q;
    endtask
    task bit_io(input b, output r);
        sda_low_o <= !b; q;
        scl_o <= 1'b1; q; q;
        r = sda_i;
        scl_o <= 1'b0; q;
    endtask
    task wbyte(input [7:0] d, output ack);
        reg r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task rbyte(input last, output [7:0] d);
        reg r;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(last, r);
    endtask
endmodule // i2c_host_model

// *** testbench/tb_power_monitor_snapshot_control.sv ***
// Testbench for the snapshot controller
`timescale 1ns/1ps
module tb_power_monitor_snapshot_control;
    localparam HOLD = 2000;
    reg        ref_clk_i = 1'b0;
    reg        rst_i = 1'b1;
    reg        power_down_n_i = 1'b1;
    reg        slow_i = 1'b0;
    reg        conv_done_i = 1'b0;
    reg [15:0] vbus_i = 16'h1000;
    reg [15:0] vsense_i = 16'h0200;
    reg        clr = 1'b0;
    reg [3:0]  seen = 4'h0;
    reg        slept = 1'b0;
    reg        ack;
    reg [7:0]  d0, d1;
    reg [15:0] ca, vb;
    wire       scl_i, host_low, sda_oe_o, conv_start_o, sleep_o;
    wire [1:0] mux_sel_o;
    wire       sda_i = !(host_low | sda_oe_o);
    integer    n_mismatch = 0;
    integer    n_tests = 0;
    always #4 ref_clk_i = ~ref_clk_i;
    power_monitor_snapshot_control #(.HOLD_CYCLES(HOLD), .PER_1024(400), .PER_256(800),
        .PER_64(1600), .PER_8(3200)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .power_down_n_i(power_down_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(),
        .sda_oe_o(sda_oe_o), .slow_i(slow_i), .mux_sel_o(mux_sel_o), .conv_start_o(conv_start_o),
        .conv_done_i(conv_done_i), .vbus_i(vbus_i), .vsense_i(vsense_i), .sleep_o(sleep_o));
    i2c_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(host_low));
    always @(posedge ref_clk_i) begin
        conv_done_i <= conv_start_o;
        if (conv_start_o) begin
            vbus_i <= vbus_i + 16'h0104;
            vsense_i <= vsense_i + 16'h0011;
        end
        seen <= clr ? 4'h0 : seen | ({3'h0, conv_start_o} << mux_sel_o);
        slept <= !clr & (slept | sleep_o);
    end
    task check(input [31:0] got, input [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input [6:0] a, input [7:0] c, input exp_ack);
        host.bus_start;
        host.wbyte({a, 1'b0}, ack);
        check(ack, exp_ack);
        if (ack) host.wbyte(c, ack);
        host.bus_stop;
    endtask
    task snap(input [6:0] a, input [7:0] c);
        cmd(a, c, 1'b1);
        cmd(7'h10, 8'h01, 1'b0);
        repeat (HOLD) @(posedge ref_clk_i);
    endtask
    task wreg(input [7:0] v);
        host.bus_start;
        host.wbyte(8'h20, ack);
        host.wbyte(8'h01, ack);
        host.wbyte(v, ack);
        host.bus_stop;
    endtask
    task rd(input [7:0] p);
        cmd(7'h10, p, 1'b1);
        host.bus_start;
        host.wbyte(8'h21, ack);
        host.rbyte(1'b0, d0);
        host.rbyte(1'b1, d1);
        host.bus_stop;
    endtask
    task win(input integer n);
        clr <= 1'b1;
        @(posedge ref_clk_i);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk_i);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        win(900);
        check(seen, 4'hF);
        check(slept, 1'b0);
        rd(8'h01);
        check(d0, 8'h0F);
        snap(7'h10, 8'h00);
        repeat (4000) @(posedge ref_clk_i);
        snap(7'h10, 8'h1F);
        rd(8'h04);
        ca = {d0, d1};
        rd(8'h10);
        vb = {d0, d1};
        repeat (3000) @(posedge ref_clk_i);
        rd(8'h10);
        check({d0, d1}, vb);
        snap(7'h10, 8'h1F);
        rd(8'h04);
        check({d0, d1} > ca, 1'b1);
        rd(8'h10);
        check({d0, d1} != vb, 1'b1);
        snap(7'h00, 8'h1E);
        snap(7'h10, 8'h00);
        rd(8'h04);
        check({d0, d1} < ca, 1'b1);
        cmd(7'h11, 8'h1E, 1'b0);
        cmd(7'h10, 8'h01, 1'b1);
        wreg(8'h4F);
        win(2000);
        check(slept, 1'b0);
        snap(7'h10, 8'h00);
        win(2000);
        check(slept, 1'b1);
        check(seen, 4'hF);
        wreg(8'h07);
        snap(7'h10, 8'h1F);
        win(2000);
        check(seen, 4'h7);
        check(slept, 1'b1);
        wreg(8'h2F);
        snap(7'h10, 8'h1F);
        win(3000);
        check(seen, 4'h0);
        rd(8'h01);
        check(d0, 8'h2F);
        wreg(8'h0F);
        snap(7'h10, 8'h1F);
        win(1500);
        check(seen, 4'hF);
        check(slept, 1'b0);
        slow_i <= 1'b1;
        win(7000);
        check(slept, 1'b1);
        slow_i <= 1'b0;
        wreg(8'h47);
        power_down_n_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        cmd(7'h10, 8'h01, 1'b0);
        power_down_n_i <= 1'b1;
        repeat (4000) @(posedge ref_clk_i);
        rd(8'h01);
        check(d0, 8'h0F);
        stop_test;
    end
endmodule // tb_power_monitor_snapshot_control
